// File: hdl/wdt_pkg.sv
// Constants and types for the watchdog, halt and reset sequencer
package wdt_pkg;
  localparam int unsigned INSTR_DIV = 4;
  localparam int unsigned DIV_EXP_MIN = 12;
  localparam int unsigned DIV_EXP_MAX = 15;
  localparam int unsigned RC_DIV_EXP = 16;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned STARTUP_CYCLES = 1024;
  localparam int unsigned OPTION_LOAD_CYCLES = 16;
  localparam int unsigned DLY_W = 11;
  localparam int unsigned STATUS_PDF_BIT = 4;
  localparam int unsigned STATUS_TO_BIT = 5;
  localparam logic [11:0] PC_RESET = 12'h000;
  localparam logic [2:0] SP_RESET = 3'h0;
  localparam logic [7:0] PORT_DIR_RESET = 8'hFF;
  typedef enum logic [1:0] {
    ST_RESET,
    ST_RUN,
    ST_HALT,
    ST_WAKE
  } seq_state_t;
  typedef enum logic [1:0] {
    WAKE_NONE,
    WAKE_NEXT,
    WAKE_IRQ,
    WAKE_WARM
  } wake_kind_t;
endpackage

// File: hdl/wdt_tick_if.sv
// Tick and clear carrier between the sequencer and the watchdog counter
`timescale 1ns/10ps
`default_nettype none
interface wdt_tick_if;
  logic tick;
  logic clr;
  logic ovf;
  modport seq (output tick, output clr, input ovf);
  modport cnt (input tick, input clr, output ovf);
endinterface
`default_nettype wire

// File: hdl/wdt_divider.sv
// Watchdog division counter with option-selected overflow tap
`timescale 1ns/10ps
`default_nettype none
module wdt_divider #(
  parameter int unsigned CNT_W = wdt_pkg::CNT_W
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Option
  input wire logic [1:0] div_sel,
  input wire logic use_rc_div,
  // Sequencer side
  wdt_tick_if.cnt t
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic ovf;
  } div_state_t;
  div_state_t s_q, s_d;
  logic [CNT_W-1:0] last;
  always_comb begin
    s_d = s_q;
    s_d.ovf = 1'b0;
    if (use_rc_div) begin
      last = {CNT_W{1'b1}};
    end else begin
      last = CNT_W'((32'h1 << (wdt_pkg::DIV_EXP_MIN + 32'(div_sel))) - 32'h1);
    end
    if (t.clr) begin
      s_d.cnt = '0;
    end else if (t.tick) begin
      if (s_q.cnt >= last) begin
        s_d.cnt = '0;
        s_d.ovf = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + CNT_W'(1);
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign t.ovf = s_q.ovf;
endmodule
`default_nettype wire

// File: hdl/watchdog_halt_reset_control.sv
// Watchdog, halt and reset sequencing for a small 8-bit controller
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module watchdog_halt_reset_control #(
  parameter int unsigned STARTUP_CYCLES = wdt_pkg::STARTUP_CYCLES,
  parameter int unsigned OPTION_LOAD_CYCLES = wdt_pkg::OPTION_LOAD_CYCLES,
  parameter int unsigned PORTA_W = 8
) (
  // Clock and power-up reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Options
  input wire logic opt_wdt_enable,
  input wire logic opt_wdt_rc_clock,
  input wire logic [1:0] opt_wdt_div,
  input wire logic opt_wdt_rc_div16,
  input wire logic opt_kick_paired,
  input wire logic opt_rc_system_osc,
  input wire logic [PORTA_W-1:0] opt_porta_wake,
  // Pins
  input wire logic external_clear_pin_n,
  input wire logic wdt_osc_tick,
  input wire logic [PORTA_W-1:0] porta_in,
  output logic crystal_pin_b_out,
  output logic crystal_pin_b_oe,
  // Core side
  input wire logic watchdog_kick_single,
  input wire logic watchdog_kick_first,
  input wire logic watchdog_kick_second,
  input wire logic halt_exec,
  input wire logic irq_req,
  input wire logic irq_enabled,
  input wire logic stack_full,
  output logic core_hold,
  output logic sys_clk_run,
  output logic chip_reset,
  output logic warm_reset,
  output logic wake_pulse,
  output logic wake_vector,
  output logic [11:0] pc_reset_value,
  output logic [2:0] stack_pointer_reset,
  output logic [7:0] port_dir_reset,
  output logic [7:0] status_flags
);
  localparam logic [11:0] ADDR_STATUS = 12'h000;
  localparam logic [11:0] ADDR_COUNT = 12'h004;
  localparam logic [11:0] ADDR_CTRL = 12'h008;
  localparam int unsigned DLY_W = wdt_pkg::DLY_W;
  localparam logic [DLY_W-1:0] STARTUP_LOAD = DLY_W'(STARTUP_CYCLES - 1);
  localparam logic [DLY_W-1:0] RESET_LOAD = DLY_W'(STARTUP_CYCLES + OPTION_LOAD_CYCLES - 1);

  typedef struct packed {
    wdt_pkg::seq_state_t st;
    wdt_pkg::wake_kind_t wk;
    logic [DLY_W-1:0] dly;
    logic [1:0] presc;
    logic expiry_flag;
    logic powerdown_flag;
    logic first_seen;
    logic irq_pending_at_halt;
    logic [PORTA_W-1:0] porta_prev;
    logic pin_prev;
    logic warm;
    logic chip;
    logic wake;
    logic vec;
    logic sw_kick_en;
    logic [31:0] rdata;
  } seq_t;

  seq_t s_q, s_d;
  wdt_tick_if wt ();
  logic halted;
  logic kick;
  logic apb_wr;
  logic apb_rd;
  logic porta_fall;
  logic irq_wake;
  logic ovf;
  logic pin_low;

  wdt_divider #(.CNT_W(wdt_pkg::CNT_W)) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .div_sel(opt_wdt_div),
    .use_rc_div(opt_wdt_rc_clock && opt_wdt_rc_div16),
    .t(wt)
  );

  assign halted = (s_q.st == wdt_pkg::ST_HALT);
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;
  assign pin_low = !external_clear_pin_n;
  assign ovf = wt.ovf && opt_wdt_enable;
  assign porta_fall = |(s_q.porta_prev & ~porta_in & opt_porta_wake);
  assign irq_wake = irq_req && !s_q.irq_pending_at_halt;

  always_comb begin
    s_d = s_q;
    s_d.warm = 1'b0;
    s_d.chip = 1'b0;
    s_d.wake = 1'b0;
    s_d.vec = 1'b0;
    s_d.porta_prev = porta_in;
    s_d.pin_prev = pin_low;
    kick = 1'b0;
    wt.clr = 1'b0;
    wt.tick = 1'b0;
    // Prescaler runs on pclk/4 only while the system clock runs
    if (!halted) begin
      s_d.presc = s_q.presc + 2'h1;
    end
    if (opt_wdt_rc_clock) begin
      wt.tick = wdt_osc_tick && opt_wdt_enable;
    end else begin
      wt.tick = !halted && (s_q.presc == 2'(wdt_pkg::INSTR_DIV - 1)) && opt_wdt_enable;
    end
    // Software kicks, gated by the enable option
    if (opt_wdt_enable && s_q.st == wdt_pkg::ST_RUN && s_q.sw_kick_en) begin
      if (!opt_kick_paired) begin
        if (watchdog_kick_single || watchdog_kick_first) begin
          kick = 1'b1;
          s_d.powerdown_flag = 1'b0;
          s_d.expiry_flag = 1'b0;
        end
      end else begin
        if (watchdog_kick_first) begin
          s_d.first_seen = 1'b1;
        end
        if (watchdog_kick_second && (s_q.first_seen || watchdog_kick_first)) begin
          kick = 1'b1;
          s_d.first_seen = 1'b0;
          s_d.expiry_flag = 1'b0;
        end
      end
    end
    if (kick) begin
      wt.clr = 1'b1;
    end
    if (apb_wr && paddr == ADDR_CTRL) begin
      s_d.sw_kick_en = pwdata[0];
    end
    case (s_q.st)
      wdt_pkg::ST_RESET: begin
        s_d.chip = 1'b1;
        wt.clr = 1'b1;
        s_d.presc = 2'h0;
        if (s_q.dly == '0) begin
          s_d.st = wdt_pkg::ST_RUN;
          s_d.chip = 1'b0;
        end else begin
          s_d.dly = s_q.dly - DLY_W'(1);
        end
      end
      wdt_pkg::ST_RUN: begin
        if (ovf) begin
          s_d.st = wdt_pkg::ST_RESET;
          s_d.expiry_flag = 1'b1;
          s_d.dly = RESET_LOAD;
          s_d.chip = 1'b1;
        end else if (halt_exec) begin
          s_d.st = wdt_pkg::ST_HALT;
          wt.clr = 1'b1;
          s_d.presc = 2'h0;
          s_d.powerdown_flag = 1'b1;
          s_d.expiry_flag = 1'b0;
          s_d.first_seen = 1'b0;
          s_d.irq_pending_at_halt = irq_req;
        end
      end
      wdt_pkg::ST_HALT: begin
        if (ovf) begin
          s_d.expiry_flag = 1'b1;
          s_d.wk = wdt_pkg::WAKE_WARM;
          s_d.st = wdt_pkg::ST_WAKE;
          s_d.dly = STARTUP_LOAD;
        end else if (irq_wake) begin
          s_d.wk = (irq_enabled && !stack_full) ? wdt_pkg::WAKE_IRQ : wdt_pkg::WAKE_NEXT;
          s_d.st = wdt_pkg::ST_WAKE;
          s_d.dly = STARTUP_LOAD;
        end else if (porta_fall) begin
          s_d.wk = wdt_pkg::WAKE_NEXT;
          s_d.st = wdt_pkg::ST_WAKE;
          s_d.dly = STARTUP_LOAD;
        end
        if (!irq_req) begin
          s_d.irq_pending_at_halt = 1'b0;
        end
      end
      wdt_pkg::ST_WAKE: begin
        if (s_q.dly == '0) begin
          s_d.st = wdt_pkg::ST_RUN;
          s_d.wake = 1'b1;
          s_d.warm = (s_q.wk == wdt_pkg::WAKE_WARM);
          s_d.vec = (s_q.wk == wdt_pkg::WAKE_IRQ);
          s_d.wk = wdt_pkg::WAKE_NONE;
        end else begin
          s_d.dly = s_q.dly - DLY_W'(1);
        end
      end
      default: begin
        s_d.st = wdt_pkg::ST_RESET;
      end
    endcase
    // Pin reset overrides the next state, delay, prescaler and counter; flags follow the cause table
    if (pin_low) begin
      wt.clr = 1'b1;
      s_d.presc = 2'h0;
      s_d.chip = 1'b1;
      s_d.st = wdt_pkg::ST_RESET;
      s_d.dly = RESET_LOAD;
      s_d.first_seen = 1'b0;
      if (!s_q.pin_prev && halted) begin
        s_d.expiry_flag = 1'b0;
        s_d.powerdown_flag = 1'b1;
      end
    end
    s_d.rdata = 32'h0;
    if (apb_rd) begin
      case (paddr)
        ADDR_STATUS: s_d.rdata = {24'h0, status_flags};
        ADDR_COUNT: s_d.rdata = {28'h0, 2'(s_q.st), s_q.wk};
        ADDR_CTRL: s_d.rdata = {31'h0, s_q.sw_kick_en};
        default: s_d.rdata = 32'h0;
      endcase
    end else if (psel && penable) begin
      s_d.rdata = s_q.rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.st <= wdt_pkg::ST_RESET;
      s_q.dly <= RESET_LOAD;
      s_q.sw_kick_en <= 1'b1;
      s_q.pin_prev <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    status_flags = 8'h00;
    status_flags[wdt_pkg::STATUS_PDF_BIT] = s_q.powerdown_flag;
    status_flags[wdt_pkg::STATUS_TO_BIT] = s_q.expiry_flag;
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !(paddr == ADDR_STATUS || paddr == ADDR_COUNT || paddr == ADDR_CTRL);
  assign prdata = s_q.rdata;
  assign core_hold = (s_q.st != wdt_pkg::ST_RUN);
  assign sys_clk_run = !halted;
  assign chip_reset = s_q.chip;
  assign warm_reset = s_q.warm;
  assign wake_pulse = s_q.wake;
  assign wake_vector = s_q.vec;
  assign pc_reset_value = wdt_pkg::PC_RESET;
  assign stack_pointer_reset = wdt_pkg::SP_RESET;
  assign port_dir_reset = wdt_pkg::PORT_DIR_RESET;
  assign crystal_pin_b_out = s_q.presc[1];
  assign crystal_pin_b_oe = opt_rc_system_osc && !halted;
endmodule
`default_nettype wire

// File: sim/wdt_seq_props.sv
// Assertions on the ports of the watchdog, halt and reset sequencer
`timescale 1ns/10ps
`default_nettype none
module wdt_seq_props (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Inputs
  input wire logic halt_exec,
  input wire logic watchdog_kick_single,
  input wire logic opt_kick_paired,
  input wire logic opt_wdt_enable,
  input wire logic opt_rc_system_osc,
  input wire logic external_clear_pin_n,
  // Outputs
  input wire logic core_hold,
  input wire logic sys_clk_run,
  input wire logic chip_reset,
  input wire logic warm_reset,
  input wire logic crystal_pin_b_out,
  input wire logic crystal_pin_b_oe,
  input wire logic [7:0] status_flags
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence halt_taken;
    halt_exec && !core_hold;
  endsequence
  sequence quarter_wave;
    crystal_pin_b_out [*2] ##1 !crystal_pin_b_out [*2] ##1 crystal_pin_b_out;
  endsequence
  chk_halt_flags: assert property (halt_taken |=> status_flags[5:4] == 2'h1)
    else $error("halt flags wrong");
  chk_halt_clock: assert property (halt_taken |=> !sys_clk_run)
    else $error("clock runs in halt");
  chk_kick_pdf: assert property (watchdog_kick_single && !core_hold && opt_wdt_enable && !opt_kick_paired
    |=> !status_flags[4])
    else $error("kick left powerdown set");
  chk_pin_b_wave: assert property ($rose(crystal_pin_b_out) && opt_rc_system_osc
    |-> quarter_wave or ##[0:4] !sys_clk_run or ##[0:4] chip_reset)
    else $error("pin b not a quarter clock");
  chk_pin_b_drive: assert property (opt_rc_system_osc && sys_clk_run |-> crystal_pin_b_oe)
    else $error("pin b not driven");
  chk_pin_reset: assert property (!external_clear_pin_n |-> ##[1:3] chip_reset)
    else $error("pin reset ignored");
  chk_wdog_off: assert property (!opt_wdt_enable |-> !$rose(status_flags[5]) && !warm_reset)
    else $error("disabled watchdog acted");
  chk_warm_flags: assert property (warm_reset |-> status_flags[5:4] == 2'h3 && !chip_reset)
    else $error("warm reset flags wrong");
endmodule
bind watchdog_halt_reset_control wdt_seq_props u_wdt_seq_props (.*);
`default_nettype wire

// File: sim/wdt_core_model.sv
// Core model issuing kick and halt instruction pulses
`timescale 1ns/10ps
`default_nettype none
module wdt_core_model (
  // Clock
  input wire logic pclk,
  // Instruction pulses
  output logic watchdog_kick_single,
  output logic watchdog_kick_first,
  output logic watchdog_kick_second,
  output logic halt_exec
);
  initial {halt_exec, watchdog_kick_second, watchdog_kick_first, watchdog_kick_single} = 4'h0;
  // One-cycle pulse: bits are halt, second, first, single
  task automatic issue(input logic [3:0] k);
    @(posedge pclk);
    {halt_exec, watchdog_kick_second, watchdog_kick_first, watchdog_kick_single} <= k;
    @(posedge pclk);
    {halt_exec, watchdog_kick_second, watchdog_kick_first, watchdog_kick_single} <= 4'h0;
  endtask
  // Paired clear, first then second
  task automatic pair;
    issue(4'h2);
    issue(4'h4);
  endtask
endmodule
`default_nettype wire

// File: sim/watchdog_halt_reset_control_tb.sv
// Testbench for the watchdog, halt and reset sequencer
`timescale 1ns/10ps
`default_nettype none
module watchdog_halt_reset_control_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 12'h000, pc_reset_value;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic opt_wdt_enable = 1, opt_wdt_rc_clock = 1, opt_kick_paired = 0, opt_rc_system_osc = 1;
  logic [1:0] opt_wdt_div = 2'h0;
  logic opt_wdt_rc_div16 = 0, external_clear_pin_n = 1, wdt_osc_tick = 0, err;
  logic [7:0] opt_porta_wake = 8'h01, porta_in = 8'hFF, port_dir_reset, status_flags;
  logic irq_req = 0, irq_enabled = 1, stack_full = 0, crystal_pin_b_out, crystal_pin_b_oe;
  logic watchdog_kick_single, watchdog_kick_first, watchdog_kick_second, halt_exec;
  logic core_hold, sys_clk_run, chip_reset, warm_reset, wake_pulse, wake_vector;
  logic [2:0] stack_pointer_reset, evs;
  int error_cnt = 0, check_count = 0, n;
  assign evs = {~core_hold, wake_pulse | wake_vector | warm_reset, chip_reset};
  initial forever #2.5 pclk = ~pclk;
  always @(posedge pclk) wdt_osc_tick <= ~wdt_osc_tick;
  watchdog_halt_reset_control #(.STARTUP_CYCLES(8), .OPTION_LOAD_CYCLES(4)) u_watchdog_halt_reset_control (.*);
  wdt_core_model u_core (.*);
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic wt(input int s, input int lim);
    n = 0;
    while (evs[s] !== 1'b1 && n < lim) begin
      @(negedge pclk);
      n++;
    end
  endtask
  task automatic boot(input logic e, input logic r, input logic p);
    @(posedge pclk) {presetn, opt_wdt_enable, opt_wdt_rc_clock, opt_kick_paired} <= {1'b0, e, r, p};
    repeat (4) @(posedge pclk);
    presetn <= 1;
    wt(2, 200);
    cmp(status_flags, 8'h00);
  endtask
  task automatic halt_now;
    u_core.issue(4'h8);
    repeat (3) @(negedge pclk);
    cmp(sys_clk_run, 0);
    cmp(status_flags[5:4], 2'h1);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #500000;
    error_cnt++;
    conclude;
  end
  initial begin
    boot(1, 1, 0);
    apb(0, 12'h008, 0); cmp(rd, 1);
    apb(1, 12'h008, 1); apb(0, 12'h000, 0); cmp(rd, 0);
    apb(0, 12'h0FC, 0); cmp(err, 1);
    halt_now;
    @(posedge pclk) porta_in <= 8'hFD;
    repeat (20) @(negedge pclk);
    cmp(sys_clk_run, 0);
    @(posedge pclk) porta_in <= 8'hFC;
    wt(1, 100); cmp(n >= 8 && n <= 12, 1);
    cmp({warm_reset, wake_vector}, 0);
    porta_in <= 8'hFF; wt(2, 50);
    u_core.issue(4'h1); @(negedge pclk); cmp(status_flags[4], 0);
    irq_req <= 1; halt_now; repeat (20) @(negedge pclk); cmp(sys_clk_run, 0);
    @(posedge pclk) irq_req <= 0; @(posedge pclk) irq_req <= 1;
    wt(1, 100); cmp(wake_vector, 1);
    irq_req <= 0; wt(2, 50);
    stack_full <= 1; halt_now; @(posedge pclk) irq_req <= 1;
    wt(1, 100); cmp({warm_reset, wake_vector}, 0);
    {irq_req, stack_full} <= 2'h0; wt(2, 50);
    irq_enabled <= 0; halt_now; @(posedge pclk) irq_req <= 1;
    wt(1, 100); cmp({warm_reset, wake_vector}, 0);
    {irq_req, irq_enabled} <= 2'h1; wt(2, 50);
    halt_now; wt(1, 9000); cmp(n >= 8185 && n <= 8240, 1);
    cmp(warm_reset, 1); cmp(status_flags[5:4], 2'h3);
    wt(2, 50); halt_now;
    @(posedge pclk) external_clear_pin_n <= 0; repeat (2) @(posedge pclk); external_clear_pin_n <= 1;
    wt(0, 10); wt(2, 200); cmp(status_flags[5:4], 2'h1);
    boot(1, 0, 0); repeat (1000) @(posedge pclk);
    u_core.issue(4'h1); wt(0, 17000); cmp(n >= 16370 && n <= 16400, 1);
    wt(2, 200); cmp(status_flags[5], 1);
    boot(1, 1, 1); u_core.issue(4'h2); wt(0, 8400); cmp(n >= 8000 && n < 8400, 1);
    wt(2, 200); repeat (5000) @(posedge pclk);
    u_core.pair; wt(0, 6000); cmp(n, 6000);
    boot(0, 1, 0); wt(0, 10000); cmp(n, 10000);
    conclude;
  end
endmodule
`default_nettype wire
